// ### wcp_seg4_match.v
// fourth-segment byte selection, crc accumulation and compare per wake type
`timescale 1ns/10ps
`default_nettype none
`include "wcp_defines.vh"

module wcp_seg4_match (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // indirect register access, already resolved to device and index
  input  wire        mmd_wr_i,
  input  wire        mmd_rd_i,
  input  wire [4:0]  mmd_dev_i,
  input  wire [15:0] mmd_reg_i,
  input  wire [15:0] mmd_wdata_i,
  output reg  [15:0] mmd_rdata_o,
  output reg         mmd_rvalid_o,
  // received byte stream, byte 1 is the first after rx_last_i
  input  wire        rx_valid_i,
  output wire        rx_ready_o,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_last_i,
  // per type result at packet end
  output reg  [3:0]  match_o,
  output reg         done_o
);

  reg  [15:0] mask_reg [0:3];
  reg  [15:0] exp_crc  [0:3];
  reg  [15:0] crc      [0:3];
  reg  [10:0] byte_num;
  reg  [15:0] next_crc [0:3];
  reg  [15:0] next_rdata;
  reg  [3:0]  next_match;
  reg  [3:0]  wr_mask_sel;
  reg  [3:0]  wr_exp_sel;
  reg  [3:0]  sel_byte;
  reg         in_seg4;
  wire        dev_hit;
  wire        buf_valid;
  wire        buf_ready;
  wire [8:0]  buf_data;
  wire [7:0]  cur_byte;
  wire        cur_last;
  wire        take;
  wire [10:0] seg_off;
  integer     t;
  integer     wt;
  integer     st;

  // two entries let a byte land while a register write stalls the engine,
  // so the source only sees ready drop once both slots are taken
  wcp_buf2 #(
    .WIDTH(`WCP_BUF_WIDTH)
  ) u_buf (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .in_valid_i (rx_valid_i),
    .in_ready_o (rx_ready_o),
    .in_data_i  ({rx_last_i, rx_data_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o (buf_data)
  );

  // a register write stalls the crc engine so a mask never changes mid-byte
  assign buf_ready = ~mmd_wr_i;
  assign take      = buf_valid & buf_ready;
  assign cur_byte  = buf_data[7:0];
  assign cur_last  = buf_data[8];
  assign dev_hit   = (mmd_dev_i == `WCP_MMD_DEV);
  assign seg_off   = byte_num - `WCP_SEG4_FIRST_BYTE;

  // msb-first, one shift per data bit; a whole byte folds in one cycle,
  // which costs eight xor stages but keeps up with one byte per clock
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (r[15] ^ d[i])
          r = {r[14:0], 1'b0} ^ `WCP_CRC_POLY;
        else
          r = {r[14:0], 1'b0};
      end
      crc_step = r;
    end
  endfunction

  // address decode; only device 1Fh answers, other devices read zero
  // an unmapped index still raises rvalid so the master never waits
  always @* begin
    wr_mask_sel = 4'h0;
    wr_exp_sel  = 4'h0;
    next_rdata  = 16'h0000;
    if (dev_hit) begin
      case (mmd_reg_i)
        `WCP_IDX_T0_SEG4: begin
          wr_mask_sel = 4'h1;
          next_rdata  = mask_reg[0];
        end
        `WCP_IDX_T1_SEG4: begin
          wr_mask_sel = 4'h2;
          next_rdata  = mask_reg[1];
        end
        `WCP_IDX_T2_SEG4: begin
          wr_mask_sel = 4'h4;
          next_rdata  = mask_reg[2];
        end
        `WCP_IDX_T3_SEG4: begin
          wr_mask_sel = 4'h8;
          next_rdata  = mask_reg[3];
        end
        `WCP_IDX_T0_EXP_CRC: begin
          wr_exp_sel = 4'h1;
          next_rdata = exp_crc[0];
        end
        `WCP_IDX_T1_EXP_CRC: begin
          wr_exp_sel = 4'h2;
          next_rdata = exp_crc[1];
        end
        `WCP_IDX_T2_EXP_CRC: begin
          wr_exp_sel = 4'h4;
          next_rdata = exp_crc[2];
        end
        `WCP_IDX_T3_EXP_CRC: begin
          wr_exp_sel = 4'h8;
          next_rdata = exp_crc[3];
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  // byte selection and crc update for each type
  always @* begin
    in_seg4  = (byte_num >= `WCP_SEG4_FIRST_BYTE) &&
               (byte_num <= `WCP_SEG4_LAST_BYTE);
    // byte_num numbers the byte at the buffer head; seg_off is only
    // meaningful inside the segment, which in_seg4 gates
    sel_byte = seg_off[3:0];
    for (t = 0; t < `WCP_NUM_TYPES; t = t + 1) begin
      if (in_seg4 && mask_reg[t][sel_byte]) begin
        next_crc[t] = crc_step(crc[t], cur_byte);
      end else begin
        // cleared bit or byte outside 49..64 leaves the crc as it is
        next_crc[t] = crc[t];
      end
      // the compare sees the crc including the byte now consumed
      next_match[t] = (next_crc[t] == exp_crc[t]);
    end
  end

  // writes to other devices or unmapped indices change nothing
  // a read answer stands one cycle and is zero when no read was taken
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (wt = 0; wt < `WCP_NUM_TYPES; wt = wt + 1) begin
        mask_reg[wt] <= `WCP_MASK_RESET;
        exp_crc[wt]  <= `WCP_EXP_RESET;
      end
      mmd_rdata_o  <= 16'h0000;
      mmd_rvalid_o <= 1'b0;
    end else begin
      for (wt = 0; wt < `WCP_NUM_TYPES; wt = wt + 1) begin
        if (mmd_wr_i && wr_mask_sel[wt])
          mask_reg[wt] <= mmd_wdata_i;
        if (mmd_wr_i && wr_exp_sel[wt])
          exp_crc[wt] <= mmd_wdata_i;
      end
      mmd_rvalid_o <= mmd_rd_i;
      mmd_rdata_o  <= mmd_rd_i ? next_rdata : 16'h0000;
    end
  end

  // done and match are registered so both stand exactly one cycle
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      byte_num <= 11'h001;
      match_o  <= 4'h0;
      done_o   <= 1'b0;
      for (st = 0; st < `WCP_NUM_TYPES; st = st + 1)
        crc[st] <= `WCP_CRC_INIT;
    end else begin
      done_o  <= take & cur_last;
      match_o <= (take & cur_last) ? next_match : 4'h0;
      if (take) begin
        if (cur_last) begin
          // next packet restarts numbering and accumulation; the last
          // byte is judged through next_crc but never stored
          byte_num <= 11'h001;
          for (st = 0; st < `WCP_NUM_TYPES; st = st + 1)
            crc[st] <= `WCP_CRC_INIT;
        end else begin
          // saturate so long frames never wrap back into the segment
          if (byte_num != `WCP_BYTE_CNT_MAX)
            byte_num <= byte_num + 11'h001;
          for (st = 0; st < `WCP_NUM_TYPES; st = st + 1)
            crc[st] <= next_crc[st];
        end
      end
    end
  end

endmodule // wcp_seg4_match

`default_nettype wire

// ### wcp_defines.vh
// constants for the customized wake packet fourth-segment byte selection
`ifndef WCP_DEFINES_VH
`define WCP_DEFINES_VH

`define WCP_MMD_DEV          5'h1F
`define WCP_IDX_T0_SEG4      16'h0004
`define WCP_IDX_T1_SEG4      16'h000A
`define WCP_IDX_T2_SEG4      16'h0010
`define WCP_IDX_T3_SEG4      16'h0016
`define WCP_IDX_T0_EXP_CRC   16'h0005
`define WCP_IDX_T1_EXP_CRC   16'h000B
`define WCP_IDX_T2_EXP_CRC   16'h0011
`define WCP_IDX_T3_EXP_CRC   16'h0017
`define WCP_MASK_RESET       16'h0000
`define WCP_EXP_RESET        16'h0000
`define WCP_SEG4_FIRST_BYTE  11'h031
`define WCP_SEG4_LAST_BYTE   11'h040
`define WCP_BYTE_CNT_MAX     11'h7FF
`define WCP_CRC_POLY         16'h1021
`define WCP_CRC_INIT         16'hFFFF
`define WCP_NUM_TYPES        4
`define WCP_BUF_WIDTH        9

`endif

// ### wcp_buf2.v
// two-entry valid/ready buffer for received packet bytes
`timescale 1ns/10ps
`default_nettype none

module wcp_buf2 #(
  parameter WIDTH = 9
) (
  input  wire             clk_sys_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       count;
  reg             ready;
  reg             not_empty;
  wire            push;
  wire            pop;

  // flags are flops so the ready seen by the source has no combinational path
  assign in_ready_o  = ready;
  assign out_valid_o = not_empty;
  assign out_data_o  = slot0;
  assign push        = in_valid_i & ready;
  assign pop         = not_empty & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      count     <= 2'h0;
      ready     <= 1'b1;
      not_empty <= 1'b0;
      slot0     <= {WIDTH{1'b0}};
      slot1     <= {WIDTH{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0)
            slot0 <= in_data_i;
          else
            slot1 <= in_data_i;
          count     <= count + 2'h1;
          ready     <= (count != 2'h1);
          not_empty <= 1'b1;
        end
        2'b01: begin
          slot0     <= slot1;
          count     <= count - 2'h1;
          ready     <= 1'b1;
          not_empty <= (count == 2'h2);
        end
        2'b11: begin
          if (count == 2'h1)
            slot0 <= in_data_i;
          else begin
            slot0 <= slot1;
            slot1 <= in_data_i;
          end
        end
        default: begin
          count <= count;
        end
      endcase
    end
  end

endmodule // wcp_buf2

`default_nettype wire

// ### wcp_seg4_match_monitor.sv
// checker for register answers and packet-end results
`timescale 1ns/10ps
`default_nettype none
module wcp_seg4_match_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        mmd_wr_i,
  input wire logic        mmd_rd_i,
  input wire logic [4:0]  mmd_dev_i,
  input wire logic [15:0] mmd_reg_i,
  input wire logic [15:0] mmd_wdata_i,
  input wire logic [15:0] mmd_rdata_o,
  input wire logic        mmd_rvalid_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_ready_o,
  input wire logic        rx_last_i,
  input wire logic [3:0]  match_o,
  input wire logic        done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire take = rx_valid_i && rx_ready_o && rx_last_i;
  wire m0 = mmd_dev_i == 5'h1f && mmd_reg_i == 16'h0004;
  a_rd_answer: assert property (mmd_rd_i |=> mmd_rvalid_o)
    else $error("read not answered");
  a_rv_idle: assert property (!mmd_rd_i |=> !mmd_rvalid_o)
    else $error("stray read answer");
  a_other_dev: assert property (mmd_rd_i && mmd_dev_i != 5'h1f
    |=> mmd_rdata_o == 16'h0000) else $error("foreign device answered");
  a_wr_rd: assert property (mmd_wr_i && m0 ##2 mmd_rd_i && m0
    |=> mmd_rdata_o == $past(mmd_wdata_i, 3)) else $error("mask lost");
  a_match_done: assert property (match_o != 4'h0 |-> done_o)
    else $error("match outside done");
  a_done_cause: assert property (take |-> ##[2:12] done_o)
    else $error("no done after last byte");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_rst_clear: assert property ($fell(rst_i)
    |-> rx_ready_o && !done_o && !mmd_rvalid_o) else $error("reset state");
  c_match: cover property (done_o && match_o != 4'h0);
  c_full: cover property (!rx_ready_o && rx_valid_i);
  c_read: cover property (mmd_rvalid_o && mmd_rdata_o != 16'h0000);
endmodule // wcp_seg4_match_monitor
`default_nettype wire

// ### wcp_sta_model.sv
// station management model issuing one-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module wcp_sta_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  logic        wr_o = 0,
  output var  logic        rd_o = 0,
  output var  logic [4:0]  dev_o = 0,
  output var  logic [15:0] reg_o = 0,
  output var  logic [15:0] wdata_o = 0
);
  task automatic xfer(input logic w, input logic [4:0] d,
                      input logic [15:0] r, v, output logic [15:0] q);
    @(posedge clk_sys_i) #1;
    {wr_o, rd_o, dev_o, reg_o, wdata_o} = {w, !w, d, r, v};
    @(posedge clk_sys_i) #1;
    // the answer stands until the next edge; take it before releasing
    q = rvalid_i ? rdata_i : 16'hxxxx;
    // released lines must not keep showing the last value
    {wr_o, rd_o, dev_o, reg_o, wdata_o} = {2'b00, ~dev_o, ~reg_o, ~wdata_o};
  endtask
endmodule // wcp_sta_model
`default_nettype wire

// ### tb_wcp_seg4_match.sv
// testbench for segment-four byte selection and crc matching
`timescale 1ns/10ps
`default_nettype none
module tb_wcp_seg4_match;
  logic clk_sys_i = 0, rst_i = 1, rx_valid_i = 0, rx_last_i = 0;
  logic [7:0] rx_data_i = 0;
  logic [15:0] mmd_rdata_o, mmd_reg_i, mmd_wdata_i, q, e, mask [4];
  logic [4:0] mmd_dev_i;
  logic mmd_wr_i, mmd_rd_i, mmd_rvalid_o, rx_ready_o, done_o;
  logic [3:0] match_o, exp_m;
  logic [7:0] pkt [80];
  integer seed = 32'h9a70332f, mismatches = 0, tests_run = 0, k, t, n;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  wcp_seg4_match dut (.*);
  wcp_sta_model pm (.clk_sys_i, .rdata_i(mmd_rdata_o),
    .rvalid_i(mmd_rvalid_o), .wr_o(mmd_wr_i), .rd_o(mmd_rd_i),
    .dev_o(mmd_dev_i), .reg_o(mmd_reg_i), .wdata_o(mmd_wdata_i));
  function automatic logic [15:0] crc(input logic [15:0] m, input int len);
    logic [15:0] c = 16'hffff;
    for (int i = 48; i < 64 && i < len; i++)
      if (m[i-48])
        for (int b = 7; b >= 0; b--)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ pkt[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // waits on the live signal: done when on_done is set, else ready
  task automatic hold(input bit on_done);
    for (int i = 0; (on_done ? done_o : rx_ready_o) !== 1'b1; i++) begin
      if (i > 50) begin
        mismatches++;
        results;
      end
      @(posedge clk_sys_i) #1;
    end
  endtask
  task automatic send(input int len);
    for (int i = 0; i < len; i++) begin
      {rx_valid_i, rx_data_i, rx_last_i} = {1'b1, pkt[i], i == len - 1};
      hold(1'b0);
      @(posedge clk_sys_i) #1;
    end
    {rx_valid_i, rx_data_i} = {1'b0, ~rx_data_i};
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1 rst_i = 0;
    for (t = 0; t < 4; t++) begin
      pm.xfer(0, 5'h1f, 16'h0004 + 6 * t, 16'h0000, q);
      chk(q, 16'h0000);
    end
    pm.xfer(0, 5'h1f, 16'h0003, 16'h0000, q);
    chk(q, 16'h0000);
    // lengths 56, 64, 72: last byte inside, at and past the segment
    for (n = 0; n < 3; n++) begin
      for (k = 0; k < 80; k++)
        pkt[k] = $random(seed);
      mask = '{$random(seed), 16'h8000, 16'h0001, n == 2 ? 0 : $random(seed)};
      exp_m = $random(seed);
      for (t = 0; t < 4; t++) begin
        e = crc(mask[t], 56 + 8 * n) ^ {15'h0000, !exp_m[t]};
        pm.xfer(1, 5'h1f, 16'h0005 + 6 * t, e, q);
        pm.xfer(1, 5'h1f, 16'h0004 + 6 * t, mask[t], q);
        pm.xfer(0, 5'h1f, 16'h0004 + 6 * t, 16'h0000, q);
        chk(q, mask[t]);
        pm.xfer(0, 5'h1f, 16'h0005 + 6 * t, 16'h0000, q);
        chk(q, e);
      end
      fork
        send(56 + 8 * n);
        repeat (3) pm.xfer(1, 5'h02, 16'h0004, 16'hffff, q);
      join
      hold(1'b1);
      chk(match_o, exp_m);
      pm.xfer(0, 5'h02, 16'h0004, 16'h0000, q);
      chk(q, 16'h0000);
      pm.xfer(0, 5'h1f, 16'h0004, 16'h0000, q);
      chk(q, mask[0]);
    end
    results;
  end
endmodule // tb_wcp_seg4_match
bind wcp_seg4_match wcp_seg4_match_monitor mon (.*);
`default_nettype wire
